/* File: core/ccm_pkg.sv */
// package: strap codes, mode enum and multiplier constants for clock mode select
package ccm_pkg;
  localparam logic [2:0] CCM_STRAP_X4     = 3'h7;
  localparam logic [2:0] CCM_STRAP_X3     = 3'h6;
  localparam logic [2:0] CCM_STRAP_X8     = 3'h5;
  localparam logic [2:0] CCM_STRAP_X5     = 3'h4;
  localparam logic [2:0] CCM_STRAP_DIRECT = 3'h3;
  localparam logic [2:0] CCM_STRAP_X10    = 3'h2;
  localparam logic [2:0] CCM_STRAP_DIV2   = 3'h1;
  localparam logic [2:0] CCM_STRAP_RSVD   = 3'h0;
  localparam logic [2:0] CCM_STRAP_DEFAULT = CCM_STRAP_X4;

  localparam logic [3:0] CCM_MUL_1  = 4'h1;
  localparam logic [3:0] CCM_MUL_3  = 4'h3;
  localparam logic [3:0] CCM_MUL_4  = 4'h4;
  localparam logic [3:0] CCM_MUL_5  = 4'h5;
  localparam logic [3:0] CCM_MUL_8  = 4'h8;
  localparam logic [3:0] CCM_MUL_10 = 4'hA;
  localparam logic [3:0] CCM_MUL_0  = 4'h0;

  typedef enum logic [2:0] {
    CCM_MODE_PLL,
    CCM_MODE_DIRECT,
    CCM_MODE_PRESCALE,
    CCM_MODE_INVALID
  } ccm_mode_t;
endpackage

/* File: core/ccm_edge_gen.sv */
// half-period tick generator: one toggle and edge pulse per clock
`timescale 1ns/100ps
`default_nettype none
module ccm_edge_gen
  import ccm_pkg::*;
#(
  parameter int CNT_W = 16
)(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             run,
  output logic                  cpu_clk_level,
  output logic                  rise_pulse,
  output logic                  fall_pulse,
  output logic [CNT_W-1:0]      half_period_count
);
  // ----------------------------------------------------------
  // half-period timing
  // ----------------------------------------------------------
  // each rising clk edge is one half_clock_period of the modelled cpu clock
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      cpu_clk_level <= 1'b0;
    else if (run)
      cpu_clk_level <= ~cpu_clk_level;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      half_period_count <= '0;
    else if (run)
      half_period_count <= half_period_count + 1'b1;
  end

  // both edges usable as triggers
  assign rise_pulse = run && !cpu_clk_level;
  assign fall_pulse = run && cpu_clk_level;
endmodule
`default_nettype wire

/* File: core/ccm_top.sv */
// top: strap-sampled cpu clock mode selection
// Operation
// - mode taken from three straps during reset
// - codes 111/110/101/100/010 select pll multiples
// - code 011 direct drive, multiply by one
// - code 001 prescaler divides input by two
// - oscillator amplifier off only in direct drive
// - both cpu clock edges trigger operations
// - half-period is the basic timing unit
`timescale 1ns/100ps
`default_nettype none
module ccm_top
  import ccm_pkg::*;
#(
  parameter int CNT_W = 16
)(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [2:0]       clock_mode_strap_pins,
  output logic [2:0]            clock_mode_strap_field,
  output ccm_mode_t             mode,
  output logic [3:0]            pll_multiplier,
  output logic                  pll_enable,
  output logic                  prescale_div2,
  output logic                  osc_amp_enable,
  output logic                  mode_invalid,
  output logic                  cpu_clk_level,
  output logic                  rise_pulse,
  output logic                  fall_pulse,
  output logic [CNT_W-1:0]      half_clock_period
);
  logic [2:0] next_strap;
  logic       in_reset;
  ccm_mode_t  next_mode;
  logic [3:0] next_mul;
  logic       run_edges;

  // ----------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------
  // sampling every cycle in reset keeps the last level before release
  assign next_strap = clock_mode_strap_pins;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      clock_mode_strap_field <= next_strap;
  end                                          // held otherwise

  always_ff @(posedge clk)
  begin
    in_reset <= !rst_b;
  end

  // ----------------------------------------------------------
  // decode
  // ----------------------------------------------------------
  always_comb
  begin
    next_mode = CCM_MODE_PLL;
    next_mul  = CCM_MUL_0;
    unique case (clock_mode_strap_field)
      CCM_STRAP_X4:     next_mul = CCM_MUL_4;
      CCM_STRAP_X3:     next_mul = CCM_MUL_3;
      CCM_STRAP_X8:     next_mul = CCM_MUL_8;
      CCM_STRAP_X5:     next_mul = CCM_MUL_5;
      CCM_STRAP_X10:    next_mul = CCM_MUL_10;
      CCM_STRAP_DIRECT:
      begin
        next_mode = CCM_MODE_DIRECT;
        next_mul  = CCM_MUL_1;
      end
      CCM_STRAP_DIV2:   next_mode = CCM_MODE_PRESCALE;
      CCM_STRAP_RSVD:   next_mode = CCM_MODE_INVALID;
    endcase
  end

  // registered outputs; mode reloads next_mode every cycle outside reset
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      mode           <= CCM_MODE_PLL;
      pll_multiplier <= CCM_MUL_0;
    end
    else
    begin
      mode           <= next_mode;
      pll_multiplier <= next_mul;
    end
  end

  assign pll_enable     = rst_b && !in_reset && (mode == CCM_MODE_PLL);
  assign prescale_div2  = rst_b && (mode == CCM_MODE_PRESCALE);
  // amp needed for crystal in every mode but direct drive
  assign osc_amp_enable = !(rst_b && mode == CCM_MODE_DIRECT);
  assign mode_invalid   = rst_b && (mode == CCM_MODE_INVALID);

  // ----------------------------------------------------------
  // half-period engine
  // ----------------------------------------------------------
  // no clock runs while reset or on a reserved code
  // decode, not mode, gates it: the mode register still holds its
  // reset value on the first edge, which would let one edge slip
  assign run_edges = rst_b && (next_mode != CCM_MODE_INVALID);

  ccm_edge_gen #(
    .CNT_W (CNT_W)
  ) u_edge (
    .clk               (clk),
    .rst_b             (rst_b),
    .run               (run_edges),
    .cpu_clk_level     (cpu_clk_level),
    .rise_pulse        (rise_pulse),
    .fall_pulse        (fall_pulse),
    .half_period_count (half_clock_period)
  );

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  sequence s_released;
    $rose(rst_b);
  endsequence

  property p_strap_sampled;
    @(posedge clk) !rst_b |=> clock_mode_strap_field == $past(clock_mode_strap_pins);
  endproperty
  a_strap_sampled: assert property (p_strap_sampled)
    else $error("strap not sampled in reset");

  property p_strap_held;
    @(posedge clk) disable iff (!rst_b)
      $past(rst_b) |-> $stable(clock_mode_strap_field);
  endproperty
  a_strap_held: assert property (p_strap_held)
    else $error("strap changed after reset");

  property p_x4;
    @(posedge clk) disable iff (!rst_b)
      s_released ##1 (clock_mode_strap_field == CCM_STRAP_X4)
      |-> pll_multiplier == CCM_MUL_4 && pll_enable;
  endproperty
  a_x4: assert property (p_x4)
    else $error("default code not x4 pll");

  property p_x10;
    @(posedge clk) disable iff (!rst_b)
      $past(rst_b) && clock_mode_strap_field == CCM_STRAP_X10
      |-> pll_multiplier == CCM_MUL_10;
  endproperty
  a_x10: assert property (p_x10)
    else $error("code 010 not x10");

  property p_direct;
    @(posedge clk) disable iff (!rst_b)
      $past(rst_b) && clock_mode_strap_field == CCM_STRAP_DIRECT
      |-> mode == CCM_MODE_DIRECT && pll_multiplier == CCM_MUL_1 && !pll_enable;
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct drive decode wrong");

  property p_div2;
    @(posedge clk) disable iff (!rst_b)
      $past(rst_b) && clock_mode_strap_field == CCM_STRAP_DIV2
      |-> prescale_div2 && !pll_enable && osc_amp_enable;
  endproperty
  a_div2: assert property (p_div2)
    else $error("prescaler decode wrong");

  property p_amp;
    @(posedge clk) disable iff (!rst_b)
      osc_amp_enable == (mode != CCM_MODE_DIRECT);
  endproperty
  a_amp: assert property (p_amp)
    else $error("amplifier enable wrong");

  property p_invalid;
    @(posedge clk) disable iff (!rst_b)
      mode_invalid |-> !pll_enable && !rise_pulse && !fall_pulse;
  endproperty
  a_invalid: assert property (p_invalid)
    else $error("reserved code not blocked");

  property p_edges;
    @(posedge clk) disable iff (!rst_b)
      rise_pulse |=> (fall_pulse || mode_invalid);
  endproperty
  a_edges: assert property (p_edges)
    else $error("edges do not alternate");

  property p_half_count;
    @(posedge clk) disable iff (!rst_b)
      $past(rst_b) && !mode_invalid |=>
        half_clock_period == CNT_W'($past(half_clock_period) + 1);
  endproperty
  a_half_count: assert property (p_half_count)
    else $error("half period count skipped");

  sequence s_held_reset;
    !rst_b ##1 !rst_b;
  endsequence

  property p_x3;
    @(posedge clk) disable iff (!rst_b)
      $past(rst_b) && clock_mode_strap_field == CCM_STRAP_X3
      |-> pll_multiplier == CCM_MUL_3 && pll_enable;
  endproperty
  a_x3: assert property (p_x3)
    else $error("code 110 not x3 pll");

  property p_x8;
    @(posedge clk) disable iff (!rst_b)
      $past(rst_b) && clock_mode_strap_field == CCM_STRAP_X8
      |-> pll_multiplier == CCM_MUL_8 && pll_enable;
  endproperty
  a_x8: assert property (p_x8)
    else $error("code 101 not x8 pll");

  property p_x5;
    @(posedge clk) disable iff (!rst_b)
      $past(rst_b) && clock_mode_strap_field == CCM_STRAP_X5
      |-> pll_multiplier == CCM_MUL_5 && pll_enable;
  endproperty
  a_x5: assert property (p_x5)
    else $error("code 100 not x5 pll");

  property p_reset_quiet;
    @(posedge clk)
      s_held_reset |-> mode == CCM_MODE_PLL && pll_multiplier == CCM_MUL_0
        && !pll_enable && osc_amp_enable && !rise_pulse && !fall_pulse
        && half_clock_period == '0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not quiet in reset");

  property p_reserved_still;
    @(posedge clk) disable iff (!rst_b)
      clock_mode_strap_field == CCM_STRAP_RSVD
      |=> $stable(cpu_clk_level) && $stable(half_clock_period);
  endproperty
  a_reserved_still: assert property (p_reserved_still)
    else $error("reserved code let an edge through");

  property p_pll_late;
    @(posedge clk) disable iff (!rst_b)
      s_released |-> !pll_enable
        ##1 (pll_enable == (mode == CCM_MODE_PLL));
  endproperty
  a_pll_late: assert property (p_pll_late)
    else $error("pll enable timing after release wrong");
endmodule
`default_nettype wire

/* File: dv/ccm_src_model.sv */
// strap source model for the cpu clock mode select block
`timescale 1ns/100ps
`default_nettype none
module ccm_src_model
  import ccm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [2:0] code,
  input  wire logic [2:0] junk,
  output logic [2:0]      pins,
  output logic            ext_forced
);
  // straps settle only in reset, then float to noise
  // levels, not flops: straps are known before the first reset edge
  assign pins = rst_b ? junk : code;
  // forced clock only for direct drive, crystal otherwise
  always_ff @(posedge clk)
    ext_forced <= (code == CCM_STRAP_DIRECT);
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for cpu clock mode select
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ccm_pkg::*;
  logic        clk, rst_b, ext_forced, pll_en, div2, amp_en, inval;
  logic        lvl, rise, fall, lvl0;
  logic [2:0]  code, junk, pins, field;
  logic [3:0]  mul;
  logic [15:0] hcp, hcp0;
  ccm_mode_t   mode, em;
  int          error_cnt = 0;
  int          compares = 0;
  int          seed = 92480;

  ccm_src_model u_src (.clk(clk), .rst_b(rst_b), .code(code), .junk(junk),
    .pins(pins), .ext_forced(ext_forced));
  ccm_top #(.CNT_W(16)) u_dut (.clk(clk), .rst_b(rst_b),
    .clock_mode_strap_pins(pins), .clock_mode_strap_field(field),
    .mode(mode), .pll_multiplier(mul), .pll_enable(pll_en),
    .prescale_div2(div2), .osc_amp_enable(amp_en), .mode_invalid(inval),
    .cpu_clk_level(lvl), .rise_pulse(rise), .fall_pulse(fall),
    .half_clock_period(hcp));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string msg);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  // reference multiplier table, integers only
  function automatic int exp_mul(input int c);
    case (c)
      7: return 4;
      6: return 3;
      5: return 8;
      4: return 5;
      3: return 1;
      2: return 10;
      default: return 0;
    endcase
  endfunction

  task automatic summarize();
    if (error_cnt == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // run is about 170 cycles; 2000 leaves ample margin
  initial
  begin
    #50000;
    error_cnt++;
    summarize();
  end

  // noise on the straps outside reset
  always @(posedge clk)
    junk <= 3'($random(seed));

  initial
  begin
    rst_b = 1'b0;
    code = 3'h7;
    for (int c = 0; c < 8; c++)
    begin
      @(posedge clk);
      rst_b <= 1'b0;
      code <= c[2:0];
      repeat (12) @(posedge clk);
      @(negedge clk);
      check(16'(mul), 16'h0, "mul in reset");
      check(16'(amp_en), 16'h1, "amp in reset");
      check(16'(pll_en), 16'h0, "pll in reset");
      check(16'(rise | fall), 16'h0, "pulses in reset");
      check(hcp, 16'h0, "count in reset");
      @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      em = (c == 0) ? CCM_MODE_INVALID : (c == 3) ? CCM_MODE_DIRECT :
           (c == 1) ? CCM_MODE_PRESCALE : CCM_MODE_PLL;
      check(16'(field), 16'(c), "field");
      check(16'(mul), 16'(exp_mul(c)), "mul");
      check(16'(mode), 16'(em), "mode");
      check(16'(pll_en), 16'(em == CCM_MODE_PLL), "pll");
      check(16'(div2), 16'(c == 1), "div2");
      check(16'(amp_en), 16'(c != 3), "amp");
      check(16'(inval), 16'(c == 0), "invalid");
      check(hcp, (c == 0) ? 16'h0 : 16'h3, "count after release");
      check(16'(amp_en), 16'(!ext_forced), "amp vs source");
      repeat (4)
      begin
        lvl0 = lvl;
        hcp0 = hcp;
        @(negedge clk);
        check(16'(lvl), 16'((c == 0) ? lvl0 : !lvl0), "level");
        check(16'(rise), 16'(c != 0 && !lvl), "rise");
        check(16'(fall), 16'(c != 0 && lvl), "fall");
        check(hcp - hcp0, 16'(c != 0), "half count");
      end
      check(16'(field), 16'(c), "field held");
    end
    summarize();
  end
endmodule
`default_nettype wire
